// ---- iefb_defs.svh ----
// Purpose: Constants of the interrupt enable and flag bank.
// Assumes: Included by the edge detector, event status and bank design files.
// Notes:   Offsets are register indices on the plain register port.
`ifndef IEFB_DEFS_SVH
`define IEFB_DEFS_SVH

// ==========================================================================
// Register offsets
`define IEFB_OFF_CONTROL     4'h0
`define IEFB_OFF_PEN_ONE     4'h1
`define IEFB_OFF_PEN_TWO     4'h2
`define IEFB_OFF_EVT_STATUS  4'h3
`define IEFB_OFF_EVT_CLEAR   4'h4
`define IEFB_OFF_EVT_ENABLE  4'h5

// ==========================================================================
// Interrupt control fields
`define IEFB_BIT_GIE         7
`define IEFB_BIT_PERIPH_GROUP_ENABLE        6
`define IEFB_BIT_T0_EN       5
`define IEFB_BIT_EXT_EN      4
`define IEFB_BIT_PC_EN       3
`define IEFB_BIT_T0_FLAG     2
`define IEFB_BIT_EXT_FLAG    1
`define IEFB_BIT_PC_FLAG     0

// Unimplemented bit of the second peripheral enable register.
`define IEFB_BIT_PEN2_UNUSED 4
`define IEFB_PEN2_MASK       8'hEF

// ==========================================================================
// Event status fields
`define IEFB_EVT_EXT         0
`define IEFB_EVT_T0          1
`define IEFB_EVT_VECTOR      2

// ==========================================================================
// Reset values and vector
`define IEFB_RST_BYTE        8'h00
`define IEFB_RST_EVT         3'h0
`define IEFB_VECTOR_ADDR     16'h0004
`define IEFB_RST_VECTOR      16'h0000

`endif

// ---- iefb_pkg.sv ----
// Purpose: Types shared by the interrupt enable and flag bank.
// Assumes: Constants live in iefb_defs.svh.
// Notes:   Holds types only.
package iefb_pkg;
   typedef logic [7:0] iefb_byte_t;
   typedef logic [2:0] iefb_evt_t;
endpackage

// ---- iefb_if.sv ----
// Purpose: Carries edge and event signals between the bank and its helpers.
// Assumes: One clock domain.
// Notes:   Three modports, one for each helper and one for the bank.
`timescale 1ns/1ps
interface iefb_if;
   logic              pin;        // external pin level
   logic              edge_sel;   // 1 rising, 0 falling
   logic              edge_pulse; // valid edge seen
   iefb_pkg::iefb_evt_t evt_set;  // event pulses
   iefb_pkg::iefb_evt_t evt_clr;  // clear mask, one cycle
   logic              en_wr;      // enable register write
   iefb_pkg::iefb_evt_t en_wdata; // enable write data
   iefb_pkg::iefb_evt_t status;   // sticky status
   iefb_pkg::iefb_evt_t enable;   // enable register
   logic              irq;        // level interrupt

   modport edge_end (input pin, input edge_sel, output edge_pulse);
   modport evt_end (input evt_set, input evt_clr, input en_wr, input en_wdata,
                    output status, output enable, output irq);
   modport main_end (output pin, output edge_sel, input edge_pulse,
                     output evt_set, output evt_clr, output en_wr, output en_wdata,
                     input status, input enable, input irq);
endinterface

// ---- iefb_edge_det.sv ----
// Purpose: Detects the selected edge on the external interrupt pin.
// Assumes: The pin is synchronous to clock.
// Notes:   No edge is reported until one sample has been taken after reset.
`timescale 1ns/1ps
`include "iefb_defs.svh"
module iefb_edge_det (
   input wire logic clock,       // core clock
   input wire logic rstn,        // async reset, active low
   iefb_if.edge_end eif          // edge signals
);
   logic prev_q, prev_d;
   logic primed_q, primed_d;

   always_comb begin
      prev_d   = eif.pin;
      primed_d = 1'b1;
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         prev_q   <= 1'b0;
         primed_q <= 1'b0;
      end else begin
         prev_q   <= prev_d;
         primed_q <= primed_d;
      end
   end

   // Priming stops a pin held high through reset from faking a rising edge.
   assign eif.edge_pulse = primed_q & (eif.edge_sel ? (eif.pin & ~prev_q)
                                                    : (~eif.pin & prev_q));

   edge_rise_a: assert property (@(posedge clock) disable iff (!rstn)
      (primed_q && eif.edge_sel && eif.pin && !prev_q) |-> eif.edge_pulse)
      else $error("rising edge not reported");
   edge_fall_a: assert property (@(posedge clock) disable iff (!rstn)
      (eif.edge_pulse && !eif.edge_sel) |-> (!eif.pin && prev_q))
      else $error("falling pulse without falling edge");
endmodule // iefb_edge_det

// ---- iefb_evt_status.sv ----
// Purpose: Sticky event status, write-only clear and enable with one irq.
// Assumes: Set and clear arrive as one-cycle pulses.
// Notes:   A set in the clearing cycle wins.
`timescale 1ns/1ps
`include "iefb_defs.svh"
module iefb_evt_status (
   input wire logic clock,       // core clock
   input wire logic rstn,        // async reset, active low
   iefb_if.evt_end  eif          // event signals
);
   iefb_pkg::iefb_evt_t status_q, status_d;
   iefb_pkg::iefb_evt_t enable_q, enable_d;

   always_comb begin
      status_d = (status_q & ~eif.evt_clr) | eif.evt_set;
      enable_d = eif.en_wr ? eif.en_wdata : enable_q;
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         status_q <= `IEFB_RST_EVT;
         enable_q <= `IEFB_RST_EVT;
      end else begin
         status_q <= status_d;
         enable_q <= enable_d;
      end
   end

   assign eif.status = status_q;
   assign eif.enable = enable_q;
   assign eif.irq    = |(status_q & enable_q);

   evt_set_wins_a: assert property (@(posedge clock) disable iff (!rstn)
      (eif.evt_set[0] && eif.evt_clr[0]) |=> status_q[0])
      else $error("event lost to clear");
endmodule // iefb_evt_status

// ---- iefb_bank.sv ----
// Purpose: Interrupt enable and flag bank with request to the processor core.
// Assumes: All inputs synchronous to clock; register port answers in one cycle.
// Notes:   Peripheral flag registers and pin-change flags live outside the bank.
`timescale 1ns/1ps
`include "iefb_defs.svh"

// Function
// - While the global enable is 1 every enabled source may request service, and while it is 0 none may.
// - Sources enabled in the two peripheral enable registers request only while the peripheral-group enable is 1.
// - Each flag sets when its source condition occurs, whatever its enable and the global enable hold.
// - The pin-change summary flag reads 1 while any pin-change flag is set, is read-only, and falls once all are cleared.
// - The timer0 overflow flag sets when the timer0 count overflows.
// - The external pin flag sets when an external pin interrupt event occurs.
// - The control register holds timer0 overflow enable at bit 5, external pin enable at bit 4 and pin-change enable at bit 3.
// - Every implemented bit of the three registers resets to 0 on every reset; control bit 0, the pin-change summary, follows the external flags instead.
// - The first peripheral enable register holds eight enables from timer1 gate at bit 7 down to timer1 overflow at bit 0.
// - The second peripheral enable register holds seven enables with bit 4 unimplemented and reading 0.
// - When an enabled interrupt is taken with the global enable at 1, the global enable clears and execution goes to vector 0004h.
// - The external pin flag sets on a rising edge when edge select is 1 and on a falling edge when it is 0.
module iefb_bank #(
   parameter int PERIPH_W = 8                     // width of each peripheral bank
) (
   input  wire logic        clock,                // core clock, 50 MHz
   input  wire logic        rstn,                 // async reset, active low
   input  wire logic [3:0]  reg_addr,             // register index
   input  wire logic [7:0]  reg_wdata,            // write data
   input  wire logic        reg_wr,               // write strobe
   input  wire logic        reg_rd,               // read strobe
   output logic      [7:0]  reg_rdata,            // read data, cycle after strobe
   input  wire logic        timer0_ovf,           // timer0 overflow pulse
   input  wire logic        ext_pin,              // external interrupt pin level
   input  wire logic        ext_edge_select,      // 1 rising, 0 falling
   input  wire logic [7:0]  pin_change_flags,     // individual pin-change flags
   input  wire logic [7:0]  periph_flags_one,     // first peripheral flag bank
   input  wire logic [7:0]  periph_flags_two,     // second peripheral flag bank
   input  wire logic        irq_ack,              // core takes the interrupt
   input  wire logic        irq_return,           // core leaves the service routine
   output logic             irq_request,          // request to the core
   output logic             vector_load,          // one-cycle vector jump
   output logic      [15:0] vector_addr,          // vector address
   output logic             evt_irq               // level event interrupt
);

   // ========================================================================
   // Elaboration checks

   if (PERIPH_W != 8) begin : g_bad_width
      $error("iefb_bank: PERIPH_W must be 8");
   end

   // ========================================================================
   // Helpers

   function automatic logic reg_hit(input logic [3:0] addr, input logic [3:0] off);
      reg_hit = (addr == off);
   endfunction

   // ========================================================================
   // Helper instances

   iefb_if eif ();

   iefb_edge_det u_edge (
      .clock (clock),
      .rstn  (rstn),
      .eif   (eif)
   );

   iefb_evt_status u_evt (
      .clock (clock),
      .rstn  (rstn),
      .eif   (eif)
   );

   // ========================================================================
   // Register decode

   logic wr_ctl, wr_pen1, wr_pen2, wr_eclr, wr_een;

   always_comb begin
      wr_ctl  = reg_wr & reg_hit(reg_addr, `IEFB_OFF_CONTROL);
      wr_pen1 = reg_wr & reg_hit(reg_addr, `IEFB_OFF_PEN_ONE);
      wr_pen2 = reg_wr & reg_hit(reg_addr, `IEFB_OFF_PEN_TWO);
      wr_eclr = reg_wr & reg_hit(reg_addr, `IEFB_OFF_EVT_CLEAR);
      wr_een  = reg_wr & reg_hit(reg_addr, `IEFB_OFF_EVT_ENABLE);
   end

   // ========================================================================
   // Control and enable registers

   logic                gie_q, gie_d;
   logic                periph_group_enable_q, periph_group_enable_d;
   logic [2:0]          core_en_q, core_en_d;    // timer0, ext pin, pin change
   logic                t0_flag_q, t0_flag_d;
   logic                ext_flag_q, ext_flag_d;
   iefb_pkg::iefb_byte_t pen1_q, pen1_d;
   iefb_pkg::iefb_byte_t pen2_q, pen2_d;
   logic                pc_summary;
   logic                core_pend, periph_pend, take;

   // The summary mirrors the external flags, so it cannot be written here.
   assign pc_summary = |pin_change_flags;

   always_comb begin
      core_pend   = (t0_flag_q  & core_en_q[2])
                  | (ext_flag_q & core_en_q[1])
                  | (pc_summary & core_en_q[0]);
      periph_pend = |(periph_flags_one & pen1_q)
                  | |(periph_flags_two & pen2_q);
      take        = irq_ack & gie_q;
   end

   always_comb begin
      gie_d      = gie_q;
      periph_group_enable_d     = periph_group_enable_q;
      core_en_d  = core_en_q;
      t0_flag_d  = t0_flag_q;
      ext_flag_d = ext_flag_q;
      pen1_d     = pen1_q;
      pen2_d     = pen2_q;
      if (wr_ctl) begin
         gie_d      = reg_wdata[`IEFB_BIT_GIE];
         periph_group_enable_d     = reg_wdata[`IEFB_BIT_PERIPH_GROUP_ENABLE];
         core_en_d  = {reg_wdata[`IEFB_BIT_T0_EN], reg_wdata[`IEFB_BIT_EXT_EN],
                       reg_wdata[`IEFB_BIT_PC_EN]};
         t0_flag_d  = reg_wdata[`IEFB_BIT_T0_FLAG];
         ext_flag_d = reg_wdata[`IEFB_BIT_EXT_FLAG];
      end
      if (wr_pen1) begin
         pen1_d = reg_wdata;
      end
      if (wr_pen2) begin
         pen2_d = reg_wdata & `IEFB_PEN2_MASK;
      end
      // Returning from service re-arms the global enable; taking clears it.
      if (irq_return) begin
         gie_d = 1'b1;
      end
      if (take) begin
         gie_d = 1'b0;
      end
      // Sources set their flags regardless of any enable, and a set wins.
      if (timer0_ovf) begin
         t0_flag_d = 1'b1;
      end
      if (eif.edge_pulse) begin
         ext_flag_d = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         gie_q      <= 1'b0;
         periph_group_enable_q     <= 1'b0;
         core_en_q  <= 3'h0;
         t0_flag_q  <= 1'b0;
         ext_flag_q <= 1'b0;
         pen1_q     <= `IEFB_RST_BYTE;
         pen2_q     <= `IEFB_RST_BYTE;
      end else begin
         gie_q      <= gie_d;
         periph_group_enable_q     <= periph_group_enable_d;
         core_en_q  <= core_en_d;
         t0_flag_q  <= t0_flag_d;
         ext_flag_q <= ext_flag_d;
         pen1_q     <= pen1_d;
         pen2_q     <= pen2_d;
      end
   end

   // Software is expected to clear flags before enabling; a stale flag
   // would otherwise request at once when its enable is written.
   assign irq_request = gie_q & (core_pend | (periph_group_enable_q & periph_pend));

   // ========================================================================
   // Vector output

   // The address holds after the pulse, so a slow core may still sample it late.
   logic        vload_q, vload_d;
   logic [15:0] vaddr_q, vaddr_d;

   always_comb begin
      vload_d = take;
      vaddr_d = take ? `IEFB_VECTOR_ADDR : vaddr_q;
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         vload_q <= 1'b0;
         vaddr_q <= `IEFB_RST_VECTOR;
      end else begin
         vload_q <= vload_d;
         vaddr_q <= vaddr_d;
      end
   end

   assign vector_load = vload_q;
   assign vector_addr = vaddr_q;

   // ========================================================================
   // Event status hookup

   always_comb begin
      eif.pin      = ext_pin;
      eif.edge_sel = ext_edge_select;
      eif.evt_set  = 3'h0;
      eif.evt_set[`IEFB_EVT_EXT]    = eif.edge_pulse;
      eif.evt_set[`IEFB_EVT_T0]     = timer0_ovf;
      eif.evt_set[`IEFB_EVT_VECTOR] = take;
      eif.evt_clr  = wr_eclr ? reg_wdata[2:0] : 3'h0;
      eif.en_wr    = wr_een;
      eif.en_wdata = reg_wdata[2:0];
   end

   assign evt_irq = eif.irq;

   // ========================================================================
   // Read port

   iefb_pkg::iefb_byte_t rdata_q, rdata_d;
   iefb_pkg::iefb_byte_t ctl_view;

   always_comb begin
      ctl_view = {gie_q, periph_group_enable_q, core_en_q, t0_flag_q, ext_flag_q, pc_summary};
      rdata_d  = 8'h00;
      if (reg_rd) begin
         case (reg_addr)
            `IEFB_OFF_CONTROL:    rdata_d = ctl_view;
            `IEFB_OFF_PEN_ONE:    rdata_d = pen1_q;
            `IEFB_OFF_PEN_TWO:    rdata_d = pen2_q;
            `IEFB_OFF_EVT_STATUS: rdata_d = {5'h00, eif.status};
            `IEFB_OFF_EVT_ENABLE: rdata_d = {5'h00, eif.enable};
            default:              rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata = rdata_q;

   // ========================================================================
   // Checks

   gie_blocks_a: assert property (@(posedge clock) disable iff (!rstn)
      !gie_q |-> !irq_request)
      else $error("request while global enable is clear");
   periph_gate_a: assert property (@(posedge clock) disable iff (!rstn)
      (!periph_group_enable_q && !core_pend) |-> !irq_request)
      else $error("peripheral request without group enable");
   core_pair_a: assert property (@(posedge clock) disable iff (!rstn)
      (gie_q && t0_flag_q && core_en_q[2]) |-> irq_request)
      else $error("enabled timer0 flag not requesting");
   t0_flag_set_a: assert property (@(posedge clock) disable iff (!rstn)
      timer0_ovf |=> t0_flag_q)
      else $error("timer0 overflow flag not set");
   ext_flag_set_a: assert property (@(posedge clock) disable iff (!rstn)
      eif.edge_pulse |=> ext_flag_q)
      else $error("external pin flag not set");
   summary_flag_a: assert property (@(posedge clock) disable iff (!rstn)
      reg_rd && reg_hit(reg_addr, `IEFB_OFF_CONTROL)
      |=> reg_rdata[`IEFB_BIT_PC_FLAG] == ($past(pin_change_flags) != 8'h00))
      else $error("pin-change summary mismatch");
   pen2_unused_a: assert property (@(posedge clock) disable iff (!rstn)
      !pen2_q[`IEFB_BIT_PEN2_UNUSED])
      else $error("unimplemented enable bit set");
   vector_take_a: assert property (@(posedge clock) disable iff (!rstn)
      (irq_ack && gie_q && !irq_return) |=> (!gie_q && vector_load
                                            && vector_addr == 16'h0004))
      else $error("vector not taken");
   flag_any_en_a: assert property (@(posedge clock) disable iff (!rstn)
      (timer0_ovf && !core_en_q[2] && !gie_q) |=> t0_flag_q)
      else $error("flag gated by enables");
   pen1_write_a: assert property (@(posedge clock) disable iff (!rstn)
      wr_pen1 |=> pen1_q == $past(reg_wdata))
      else $error("peripheral enable write lost");
   reset_zero_a: assert property (@(posedge clock)
      $rose(rstn) |-> (ctl_view[7:1] == 7'h00 && pen1_q == 8'h00 && pen2_q == 8'h00))
      else $error("register not cleared by reset");
   // A return re-arms the global enable unless a take lands in the same cycle.
   ret_sets_gie_a: assert property (@(posedge clock) disable iff (!rstn)
      (irq_return && !(irq_ack && gie_q)) |=> gie_q)
      else $error("return did not set global enable");
   periph_one_a: assert property (@(posedge clock) disable iff (!rstn)
      (gie_q && periph_group_enable_q && (periph_flags_one & pen1_q) != 8'h00) |-> irq_request)
      else $error("enabled first-bank source not requesting");
   periph_two_a: assert property (@(posedge clock) disable iff (!rstn)
      (gie_q && periph_group_enable_q && (periph_flags_two & pen2_q) != 8'h00) |-> irq_request)
      else $error("enabled second-bank source not requesting");
   ctl_enable_a: assert property (@(posedge clock) disable iff (!rstn)
      (wr_ctl && !irq_return && !(irq_ack && gie_q))
      |=> {3'h0, ctl_view[7:3]} == ($past(reg_wdata) >> 3))
      else $error("control enable write lost");
   pen2_write_a: assert property (@(posedge clock) disable iff (!rstn)
      wr_pen2 |=> pen2_q == ($past(reg_wdata) & `IEFB_PEN2_MASK))
      else $error("second enable write lost");

endmodule // iefb_bank

// ---- iefb_core_model.sv ----
// Purpose: Behavioural processor core that takes and leaves interrupts.
// Assumes: One clock; it takes only while the bench allows it.
// Notes:   The request must stand ack_delay + 1 cycles before the take pulse rises.
`timescale 1ns/1ps
module iefb_core_model (
   input  wire logic       clock,       // core clock
   input  wire logic       rstn,        // async reset, active low
   input  wire logic       irq_request, // request from the bank
   input  wire logic       take_en,     // bench allows a take
   input  wire logic [3:0] ack_delay,   // take follows ack_delay + 1 request cycles
   input  wire logic       ret_cmd,     // bench asks for a return
   output logic            irq_ack,     // take pulse
   output logic            irq_return   // return pulse
);
   logic [3:0] wait_q;
   logic [3:0] wait_d;
   logic       ack_d;

   // ==========================================================================
   // Take and return
   always_comb begin
      wait_d = (irq_request && take_en && !irq_ack) ? wait_q + 4'h1 : 4'h0;
      ack_d  = irq_request && take_en && !irq_ack && (wait_q >= ack_delay);
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         wait_q     <= 4'h0;
         irq_ack    <= 1'b0;
         irq_return <= 1'b0;
      end else begin
         wait_q     <= wait_d;
         irq_ack    <= ack_d;
         irq_return <= ret_cmd;
      end
   end
endmodule // iefb_core_model

// ---- test_interrupt_enable_flag_bank.sv ----
// Purpose: Self-checking bench of the interrupt enable and flag bank.
// Assumes: Register port answers a read in the next cycle.
// Notes:   A core model takes and leaves interrupts on command.
`timescale 1ns/1ps
`include "iefb_defs.svh"
module test_interrupt_enable_flag_bank;
   logic        clock, rstn, reg_wr, reg_rd, timer0_ovf, ext_pin, ext_edge_select;
   logic [3:0]  reg_addr, ack_delay;
   logic [7:0]  reg_wdata, reg_rdata, pin_change_flags, periph_flags_one, periph_flags_two;
   logic        irq_ack, irq_return, irq_request, vector_load, evt_irq, take_en, ret_cmd;
   logic [15:0] vector_addr;
   int          errors, cmp_count;

   iefb_bank u_iefb_bank (.clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer0_ovf(timer0_ovf),
      .ext_pin(ext_pin), .ext_edge_select(ext_edge_select), .pin_change_flags(pin_change_flags),
      .periph_flags_one(periph_flags_one), .periph_flags_two(periph_flags_two), .irq_ack(irq_ack),
      .irq_return(irq_return), .irq_request(irq_request), .vector_load(vector_load),
      .vector_addr(vector_addr), .evt_irq(evt_irq));
   iefb_core_model u_iefb_core_model (.clock(clock), .rstn(rstn), .irq_request(irq_request),
      .take_en(take_en), .ack_delay(ack_delay), .ret_cmd(ret_cmd), .irq_ack(irq_ack),
      .irq_return(irq_return));

   always #10 clock = ~clock;

   // ==========================================================================
   // Shared tasks
   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr    <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
      @(posedge clock);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd   <= 1'b0;
      #1 check({8'h00, reg_rdata}, {8'h00, exp}, what);
   endtask

   task automatic t0_pulse();
      @(posedge clock);
      timer0_ovf <= 1'b1;
      @(posedge clock);
      timer0_ovf <= 1'b0;
   endtask

   task automatic pin_step(input logic v, input logic [7:0] exp);
      @(posedge clock);
      ext_pin <= v;
      repeat (3) @(posedge clock);
      rd(`IEFB_OFF_CONTROL, exp, "ext flag");
      wr(`IEFB_OFF_CONTROL, 8'h00);
   endtask

   // ==========================================================================
   // Scenarios
   task automatic t_regs();
      rd(`IEFB_OFF_CONTROL, 8'h00, "ctrl rst");
      rd(`IEFB_OFF_PEN_ONE, 8'h00, "pen1 rst");
      rd(`IEFB_OFF_PEN_TWO, 8'h00, "pen2 rst");
      wr(`IEFB_OFF_PEN_ONE, 8'hFF);
      rd(`IEFB_OFF_PEN_ONE, 8'hFF, "pen1");
      wr(`IEFB_OFF_PEN_TWO, 8'hFF);
      rd(`IEFB_OFF_PEN_TWO, 8'hEF, "pen2");
      wr(`IEFB_OFF_CONTROL, 8'h39);
      rd(`IEFB_OFF_CONTROL, 8'h38, "ctrl enables");
      wr(`IEFB_OFF_CONTROL, 8'h00);
      rd(4'hF, 8'h00, "unmapped");
   endtask

   task automatic t_flags();
      t0_pulse();
      rd(`IEFB_OFF_CONTROL, 8'h04, "t0 flag");
      check({15'h0000, irq_request}, 16'h0000, "req gie off");
      wr(`IEFB_OFF_CONTROL, 8'h00);
      pin_step(1'b1, 8'h02);
      pin_step(1'b0, 8'h00);
      ext_edge_select <= 1'b0;
      pin_step(1'b1, 8'h00);
      pin_step(1'b0, 8'h02);
      @(posedge clock);
      pin_change_flags <= 8'h81;
      rd(`IEFB_OFF_CONTROL, 8'h01, "summary set");
      wr(`IEFB_OFF_CONTROL, 8'h00);
      pin_change_flags <= 8'h01;
      rd(`IEFB_OFF_CONTROL, 8'h01, "summary held");
      pin_change_flags <= 8'h00;
      rd(`IEFB_OFF_CONTROL, 8'h00, "summary clr");
   endtask

   task automatic t_gate();
      logic [7:0] m;
      for (int b = 0; b < 2; b++) begin
         for (int i = 0; i < 8; i++) begin
            m = 8'h01 << i;
            wr(b == 0 ? `IEFB_OFF_PEN_ONE : `IEFB_OFF_PEN_TWO, m);
            @(posedge clock);
            periph_flags_one <= (b == 0) ? m : 8'h00;
            periph_flags_two <= (b == 1) ? m : 8'h00;
            wr(`IEFB_OFF_CONTROL, 8'h80);
            #1 check({15'h0000, irq_request}, 16'h0000, "periph_group_enable off");
            wr(`IEFB_OFF_CONTROL, 8'hC0);
            #1 check({15'h0000, irq_request}, {15'h0000, !(b == 1 && i == 4)}, "periph req");
            wr(`IEFB_OFF_CONTROL, 8'h40);
            #1 check({15'h0000, irq_request}, 16'h0000, "gie off");
            wr(b == 0 ? `IEFB_OFF_PEN_ONE : `IEFB_OFF_PEN_TWO, 8'h00);
            periph_flags_one <= 8'h00;
            periph_flags_two <= 8'h00;
         end
      end
   endtask

   task automatic t_take(input logic [3:0] dly);
      int n;
      wr(`IEFB_OFF_CONTROL, 8'h00);
      wr(`IEFB_OFF_CONTROL, 8'hA0);
      t0_pulse();
      #1 check({15'h0000, irq_request}, 16'h0001, "core req");
      @(posedge clock);
      ack_delay <= dly;
      take_en   <= 1'b1;
      n = 0;
      while (vector_load !== 1'b1 && n < 20) begin
         @(posedge clock);
         #1 n++;
      end
      check({15'h0000, vector_load}, 16'h0001, "vector load");
      check(vector_addr, `IEFB_VECTOR_ADDR, "vector addr");
      check({15'h0000, irq_request}, 16'h0000, "req after take");
      @(posedge clock);
      take_en <= 1'b0;
      #1 check({15'h0000, vector_load}, 16'h0000, "load pulse");
      rd(`IEFB_OFF_CONTROL, 8'h24, "gie cleared");
      @(posedge clock);
      ret_cmd <= 1'b1;
      @(posedge clock);
      ret_cmd <= 1'b0;
      repeat (2) @(posedge clock);
      rd(`IEFB_OFF_CONTROL, 8'hA4, "gie back");
      wr(`IEFB_OFF_CONTROL, 8'h00);
   endtask

   task automatic t_events();
      rd(`IEFB_OFF_EVT_STATUS, 8'h07, "evt status");
      wr(`IEFB_OFF_EVT_ENABLE, 8'h04);
      #1 check({15'h0000, evt_irq}, 16'h0001, "evt irq");
      rd(`IEFB_OFF_EVT_ENABLE, 8'h04, "evt enable");
      wr(`IEFB_OFF_EVT_CLEAR, 8'h04);
      #1 check({15'h0000, evt_irq}, 16'h0000, "evt cleared");
      wr(`IEFB_OFF_EVT_STATUS, 8'h00);
      rd(`IEFB_OFF_EVT_STATUS, 8'h03, "status ro");
      rd(`IEFB_OFF_EVT_CLEAR, 8'h00, "clear wo");
      wr(`IEFB_OFF_PEN_ONE, 8'h5A);
      @(posedge clock);
      rstn <= 1'b0;
      repeat (2) @(posedge clock);
      rstn <= 1'b1;
      rd(`IEFB_OFF_PEN_ONE, 8'h00, "pen1 rerst");
      rd(`IEFB_OFF_EVT_STATUS, 8'h00, "status rerst");
      rd(`IEFB_OFF_EVT_ENABLE, 8'h00, "enable rerst");
      check(vector_addr, 16'h0000, "vector rerst");
   endtask

   // ==========================================================================
   // Run and verdict
   task automatic summarize();
      if (errors == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   initial begin
      clock = 1'b0;
      rstn = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      timer0_ovf = 1'b0;
      ext_pin = 1'b0;
      ext_edge_select = 1'b1;
      pin_change_flags = 8'h00;
      periph_flags_one = 8'h00;
      periph_flags_two = 8'h00;
      take_en = 1'b0;
      ret_cmd = 1'b0;
      ack_delay = 4'h0;
      repeat (6) @(posedge clock);
      rstn <= 1'b1;
      t_regs();
      t_flags();
      t_gate();
      t_take(4'h0);
      t_take(4'h3);
      t_events();
      summarize();
   end

   // A hang would otherwise run forever; the tests need well under 20 us.
   initial begin
      #200000;
      errors++;
      summarize();
   end
endmodule // test_interrupt_enable_flag_bank
